// [inc/sfc_pkg.sv]
// ============================================================
// Shared constants and types of the serial flash front end
package sfc_pkg;

  // Serial framing
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned CNT_W    = 4;
  localparam logic [2:0]  BIT_LAST = 3'h7;
  localparam logic [3:0]  CNT_SAT  = 4'hf;

  // Bus cycles completed when an instruction is whole or a standard id byte is due
  localparam logic [3:0] CNT_OP        = 4'h1;
  localparam logic [3:0] CNT_STATUS_WR = 4'h2;
  localparam logic [3:0] CNT_AAI_NEXT  = 4'h3;
  localparam logic [3:0] CNT_STD_LAST  = 4'h3;
  localparam logic [3:0] CNT_ADDR      = 4'h4;
  localparam logic [3:0] CNT_FAST      = 4'h5;
  localparam logic [3:0] CNT_BYTE_PROG = 4'h5;
  localparam logic [3:0] CNT_AAI_FIRST = 4'h6;
  localparam logic [3:0] CNT_STD_TYPE  = 4'h2;

  // Opcodes
  localparam logic [7:0] OPC_NONE          = 8'h00;
  localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OPC_BYTE_PROGRAM  = 8'h02;
  localparam logic [7:0] OPC_READ          = 8'h03;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ   = 8'h05;
  localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OPC_FAST_READ     = 8'h0b;
  localparam logic [7:0] OPC_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OPC_STATUS_UNLOCK = 8'h50;
  localparam logic [7:0] OPC_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OPC_BUSY_OUT_EN   = 8'h70;
  localparam logic [7:0] OPC_BUSY_OUT_DIS  = 8'h80;
  localparam logic [7:0] OPC_MAKER_DEV_ID  = 8'h90;
  localparam logic [7:0] OPC_STD_ID        = 8'h9f;
  localparam logic [7:0] OPC_SIGNATURE     = 8'hab;
  localparam logic [7:0] OPC_WORD_PROGRAM  = 8'had;
  localparam logic [7:0] OPC_CHIP_ERASE_B  = 8'hc7;
  localparam logic [7:0] OPC_BLOCK_ERASE   = 8'hd8;

  // Status byte layout
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_WEL   = 1;
  localparam int unsigned ST_BP_LO = 2;
  localparam int unsigned ST_BP_HI = 4;
  localparam int unsigned ST_AAI   = 6;
  localparam int unsigned ST_BPL   = 7;
  localparam logic [2:0]  BP_RESET = 3'h7;

  // Pin synchroniser lanes and their idle levels
  localparam int unsigned PIN_N    = 4;
  localparam int unsigned PIN_SCK  = 0;
  localparam int unsigned PIN_CS   = 1;
  localparam int unsigned PIN_SI   = 2;
  localparam int unsigned PIN_WP   = 3;
  localparam logic [3:0]  PIN_IDLE = 4'ha;

  // Word program address step
  localparam logic [23:0] AAI_STEP      = 24'h00_0002;
  localparam logic [23:0] AAI_LAST_BYTE = 24'h00_0001;

  typedef enum logic [2:0] {
    OP_SECTOR_ERASE = 3'h0,
    OP_BLOCK_ERASE  = 3'h1,
    OP_CHIP_ERASE   = 3'h2,
    OP_BYTE_PROGRAM = 3'h3,
    OP_WORD_PROGRAM = 3'h4
  } array_op_t;

  typedef struct packed {
    array_op_t   op;
    logic [23:0] addr;
    logic [15:0] data;
  } array_req_t;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_RECV = 2'b01,
    FR_EXEC = 2'b11
  } frame_state_t;

endpackage : sfc_pkg

// [hdl/req_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Request FIFO between the command decoder and the array
module req_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ============================================================
  // Parameter check
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("req_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = (wr_ptr_q ^ rd_ptr_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_q != rd_ptr_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

  // Storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : req_fifo
`default_nettype wire

// [hdl/serial_flash_command_decoder.sv]
`timescale 1ns/1ns
`default_nettype none
// ============================================================
module serial_flash_command_decoder
  import sfc_pkg::*;
#(
  parameter int unsigned        ADDR_W     = 24,
  parameter int unsigned        FIFO_DEPTH = 16,
  parameter logic [ADDR_W-1:0]  TOP_ADDR   = '1,
  parameter logic [7:0]         SIGNATURE  = 8'h5a, // Arbitrary value
  parameter logic [7:0]         MAKER_CODE = 8'ha5, // Arbitrary value
  parameter logic [7:0]         DEV_CODE   = 8'h3c, // Arbitrary value
  parameter logic [7:0]         MEM_TYPE   = 8'h4b, // Arbitrary value
  parameter logic [7:0]         CAPACITY   = 8'h11  // Arbitrary value
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                sck,
  input  wire logic                cs_n,
  input  wire logic                si,
  input  wire logic                wp_n,
  output logic                     so,
  output logic                     so_oe_n,
  output logic      [ADDR_W-1:0]   rd_addr,
  input  wire logic [7:0]          rd_data,
  input  wire logic                array_busy,
  output logic                     req_valid,
  input  wire logic                req_ready,
  output var sfc_pkg::array_req_t  req,
  output logic                     write_enable_latch,
  output logic      [7:0]          status_byte
);
  import sfc_pkg::*;

  // ============================================================
  // Parameter check
  if (ADDR_W < 12 || ADDR_W > 24) begin : g_bad_addr
    $error("ADDR_W must lie between 12 and 24");
  end

  logic [PIN_N-1:0]  pin_raw;
  logic [PIN_N-1:0]  pin_meta_q;
  logic [PIN_N-1:0]  pin_sync_q;
  logic              sck_prev_q;
  logic              cs_prev_q;
  logic              sck_s;
  logic              cs_s;
  logic              si_s;
  logic              wp_s;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_fall;
  logic              cs_rise;
  logic              byte_done;
  logic [7:0]        rx_byte;
  logic [2:0]        bit_cnt_q;
  logic [7:0]        shift_q;
  logic [3:0]        byte_cnt_q;
  logic [3:0]        byte_cnt_d;
  logic [7:0]        opcode_q;
  logic [7:0]        prev_op_q;
  logic [23:0]       addr_q;
  logic [23:0]       addr_d;
  logic [15:0]       data_q;
  frame_state_t      frame_q;
  logic              exec;
  logic [ADDR_W-1:0] rd_addr_q;
  logic              id_flip_q;
  logic [7:0]        tx_q;
  logic [7:0]        tx_d;
  logic              drive_d;
  logic              so_q;
  logic              so_oe_n_q;
  logic              wel_q;
  logic              aai_q;
  logic [23:0]       aai_addr_q;
  logic [23:0]       aai_word;
  logic              aai_at_top;
  logic              busy_out_en_q;
  logic [2:0]        bp_q;
  logic              bpl_q;
  logic              busy;
  logic              fifo_ready;
  logic              is_erase_prog;
  logic              cmd_whole;
  logic              push;
  array_req_t        push_req;
  logic              status_write_cmd_ok;

  // ============================================================
  // Pin synchronisers, two flops per lane
  assign pin_raw[PIN_SCK] = sck;
  assign pin_raw[PIN_CS]  = cs_n;
  assign pin_raw[PIN_SI]  = si;
  assign pin_raw[PIN_WP]  = wp_n;

  for (genvar g = 0; g < PIN_N; g++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_meta_q[g] <= PIN_IDLE[g];
        pin_sync_q[g] <= PIN_IDLE[g];
      end else begin
        pin_meta_q[g] <= pin_raw[g];
        pin_sync_q[g] <= pin_meta_q[g];
      end
    end
  end

  assign sck_s = pin_sync_q[PIN_SCK];
  assign cs_s  = pin_sync_q[PIN_CS];
  assign si_s  = pin_sync_q[PIN_SI];
  assign wp_s  = pin_sync_q[PIN_WP];

  // Edge history of the serial clock and chip select
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= PIN_IDLE[PIN_SCK];
      cs_prev_q  <= PIN_IDLE[PIN_CS];
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_s;
    end
  end

  assign sck_rise  = sck_s & ~sck_prev_q & ~cs_s;
  assign sck_fall  = ~sck_s & sck_prev_q & ~cs_s;
  assign cs_fall   = ~cs_s & cs_prev_q;
  assign cs_rise   = cs_s & ~cs_prev_q;
  assign rx_byte   = {shift_q[6:0], si_s};
  assign byte_done = sck_rise && (bit_cnt_q == BIT_LAST);
  assign byte_cnt_d = (byte_cnt_q == CNT_SAT) ? CNT_SAT : 4'(byte_cnt_q + 1'b1);
  assign addr_d    = {addr_q[15:0], rx_byte};

  // ============================================================
  // Receive shifter and bit counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= '0;
      shift_q   <= '0;
    end else if (cs_fall) begin
      bit_cnt_q <= '0;
    end else if (sck_rise) begin
      bit_cnt_q <= 3'(bit_cnt_q + 1'b1);
      shift_q   <= rx_byte;
    end
  end

  // Byte count, opcode, address and data capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_q <= '0;
      opcode_q   <= OPC_NONE;
      addr_q     <= '0;
      data_q     <= '0;
    end else if (cs_fall) begin
      byte_cnt_q <= '0;
      opcode_q   <= OPC_NONE;
    end else if (byte_done) begin
      byte_cnt_q <= byte_cnt_d;
      if (byte_cnt_q == '0) begin
        opcode_q <= rx_byte;
      end else begin
        data_q <= {data_q[7:0], rx_byte};
        if (byte_cnt_d <= CNT_ADDR) begin
          addr_q <= addr_d;
        end
      end
    end
  end

  // ============================================================
  // Frame state: execute only on a whole byte boundary
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= FR_IDLE;
    end else begin
      case (frame_q)
        FR_IDLE: begin
          if (cs_fall) begin
            frame_q <= FR_RECV;
          end
        end
        FR_RECV: begin
          if (cs_rise) begin
            if (bit_cnt_q == '0 && byte_cnt_q != '0) begin
              frame_q <= FR_EXEC;
            end else begin
              frame_q <= FR_IDLE;
            end
          end
        end
        FR_EXEC: begin
          frame_q <= FR_IDLE;
        end
        default: begin
          frame_q <= FR_IDLE;
        end
      endcase
    end
  end

  assign exec = (frame_q == FR_EXEC);

  // Last completed instruction, for the status write unlock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_op_q <= OPC_NONE;
    end else if (exec) begin
      prev_op_q <= opcode_q;
    end
  end

  // ============================================================
  // Read pointer and id alternation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_q <= '0;
      id_flip_q <= 1'b0;
    end else if (byte_done) begin
      if (byte_cnt_d == CNT_ADDR) begin
        rd_addr_q <= addr_d[ADDR_W-1:0];
        id_flip_q <= rx_byte[0];
      end else begin
        if ((opcode_q == OPC_READ && byte_cnt_d > CNT_ADDR) ||
            (opcode_q == OPC_FAST_READ && byte_cnt_d > CNT_FAST)) begin
          rd_addr_q <= ADDR_W'(rd_addr_q + 1'b1);
        end
        if (byte_cnt_d > CNT_ADDR) begin
          id_flip_q <= ~id_flip_q;
        end
      end
    end
  end

  assign rd_addr = rd_addr_q;

  // Status byte as seen by the host
  assign busy = array_busy | req_valid;
  always_comb begin
    status_byte                    = '0;
    status_byte[ST_BUSY]           = busy;
    status_byte[ST_WEL]            = wel_q;
    status_byte[ST_BP_HI:ST_BP_LO] = bp_q;
    status_byte[ST_AAI]            = aai_q;
    status_byte[ST_BPL]            = bpl_q;
  end

  // ============================================================
  // Response byte for the coming bus cycle
  always_comb begin
    tx_d    = '0;
    drive_d = 1'b0;
    case (opcode_q)
      OPC_READ: begin
        drive_d = byte_cnt_q >= CNT_ADDR;
        tx_d    = rd_data;
      end
      OPC_FAST_READ: begin
        drive_d = byte_cnt_q >= CNT_FAST;
        tx_d    = rd_data;
      end
      OPC_STATUS_READ: begin
        drive_d = byte_cnt_q >= CNT_OP;
        tx_d    = status_byte;
      end
      OPC_SIGNATURE: begin
        drive_d = byte_cnt_q >= CNT_OP;
        tx_d    = SIGNATURE;
      end
      OPC_STD_ID: begin
        drive_d = byte_cnt_q >= CNT_OP && byte_cnt_q <= CNT_STD_LAST;
        tx_d    = (byte_cnt_q == CNT_OP) ? MAKER_CODE :
                  (byte_cnt_q == CNT_STD_TYPE) ? MEM_TYPE : CAPACITY;
      end
      OPC_MAKER_DEV_ID: begin
        drive_d = byte_cnt_q >= CNT_ADDR;
        tx_d    = id_flip_q ? DEV_CODE : MAKER_CODE;
      end
      default: begin
        drive_d = 1'b0;
      end
    endcase
  end

  // Serial output: shifted on falling clock; when deselected, drives ready/busy in word program with busy output on, else off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_q      <= 1'b0;
      so_oe_n_q <= 1'b1;
      tx_q      <= '0;
    end else if (cs_s) begin
      so_q      <= ~busy;
      so_oe_n_q <= ~(aai_q & busy_out_en_q);
    end else if (cs_fall) begin
      so_oe_n_q <= 1'b1;
    end else if (sck_fall) begin
      if (bit_cnt_q == '0) begin
        tx_q      <= tx_d;
        so_q      <= tx_d[BIT_LAST];
        so_oe_n_q <= ~drive_d;
      end else begin
        so_q <= tx_q[BIT_LAST - bit_cnt_q];
      end
    end
  end

  assign so      = so_q;
  assign so_oe_n = so_oe_n_q;

  // ============================================================
  // Array requests: erase and program
  assign aai_word   = {addr_q[23:1], 1'b0};
  assign aai_at_top = ((aai_q ? aai_addr_q : aai_word) | AAI_LAST_BYTE) >= 24'(TOP_ADDR);

  always_comb begin
    cmd_whole     = 1'b0;
    is_erase_prog = 1'b1;
    push_req      = '{op: OP_CHIP_ERASE, addr: addr_q, data: data_q};
    case (opcode_q)
      OPC_SECTOR_ERASE: begin
        cmd_whole   = byte_cnt_q == CNT_ADDR;
        push_req.op = OP_SECTOR_ERASE;
      end
      OPC_BLOCK_ERASE: begin
        cmd_whole   = byte_cnt_q == CNT_ADDR;
        push_req.op = OP_BLOCK_ERASE;
      end
      OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: begin
        cmd_whole   = byte_cnt_q == CNT_OP;
        push_req.op = OP_CHIP_ERASE;
      end
      OPC_BYTE_PROGRAM: begin
        cmd_whole   = byte_cnt_q == CNT_BYTE_PROG;
        push_req.op = OP_BYTE_PROGRAM;
      end
      OPC_WORD_PROGRAM: begin
        cmd_whole     = aai_q ? (byte_cnt_q == CNT_AAI_NEXT)
                              : (byte_cnt_q == CNT_AAI_FIRST);
        push_req.op   = OP_WORD_PROGRAM;
        push_req.addr = aai_q ? aai_addr_q : aai_word;
      end
      default: begin
        is_erase_prog = 1'b0;
      end
    endcase
  end

  // Word program continues only inside an open sequence
  assign push = exec && is_erase_prog && cmd_whole && wel_q && fifo_ready &&
                (!aai_q || opcode_q == OPC_WORD_PROGRAM);

  req_fifo #(
    .WIDTH ($bits(array_req_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_req_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_req),
    .out_valid (req_valid),
    .out_ready (req_ready),
    .out_data  (req)
  );

  // ============================================================
  // Write-enable latch
  assign status_write_cmd_ok = exec && opcode_q == OPC_STATUS_WRITE && byte_cnt_q == CNT_STATUS_WR &&
                   (prev_op_q == OPC_STATUS_UNLOCK || prev_op_q == OPC_WRITE_ENABLE) &&
                   !(~wp_s && bpl_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_q <= 1'b0;
    end else if (exec && byte_cnt_q == CNT_OP && opcode_q == OPC_WRITE_DISABLE) begin
      wel_q <= 1'b0;
    end else if (exec && byte_cnt_q == CNT_OP && opcode_q == OPC_WRITE_ENABLE) begin
      wel_q <= 1'b1;
    end else if (push && (opcode_q != OPC_WORD_PROGRAM || aai_at_top)) begin
      wel_q <= 1'b0;
    end else if (status_write_cmd_ok) begin
      wel_q <= 1'b0;
    end
  end

  assign write_enable_latch = wel_q;

  // Word program sequence state and next word address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aai_q      <= 1'b0;
      aai_addr_q <= '0;
    end else if (exec && byte_cnt_q == CNT_OP && opcode_q == OPC_WRITE_DISABLE) begin
      aai_q <= 1'b0;
    end else if (push && opcode_q == OPC_WORD_PROGRAM) begin
      aai_q      <= ~aai_at_top;
      aai_addr_q <= push_req.addr + AAI_STEP;
    end
  end

  // Ready/busy output control
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_out_en_q <= 1'b0;
    end else if (exec && byte_cnt_q == CNT_OP) begin
      if (opcode_q == OPC_BUSY_OUT_EN) begin
        busy_out_en_q <= 1'b1;
      end else if (opcode_q == OPC_BUSY_OUT_DIS) begin
        busy_out_en_q <= 1'b0;
      end
    end
  end

  // Protection bits written by the status write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_q  <= BP_RESET;
      bpl_q <= 1'b0;
    end else if (status_write_cmd_ok) begin
      bp_q  <= data_q[ST_BP_HI:ST_BP_LO];
      bpl_q <= data_q[ST_BPL];
    end
  end

endmodule : serial_flash_command_decoder
`default_nettype wire

// [test/sfc_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Checks at the decoder ports
module sfc_monitor (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       so_oe_n,
  input wire logic       array_busy,
  input wire logic       req_valid,
  input wire logic       write_enable_latch,
  input wire logic [7:0] status_byte
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Deselected link, and the start of a response byte
  sequence s_idle; cs_n [*4] ##0 !status_byte[6]; endsequence
  sequence s_on; $fell(so_oe_n) && !status_byte[6]; endsequence
  // Latch and status relations
  property p_rst; !$past(rst_n) |-> status_byte[7:1] == 7'h0e; endproperty
  a_rst: assert property (p_rst) else $error("reset status");
  property p_bit; status_byte[1] == write_enable_latch; endproperty
  a_bit: assert property (p_bit) else $error("latch bit");
  property p_frm; $changed(write_enable_latch) |-> $past(cs_n, 3); endproperty
  a_frm: assert property (p_frm) else $error("latch mid frame");
  property p_push; $rose(req_valid) |-> $past(write_enable_latch) && $past(cs_n, 3); endproperty
  a_push: assert property (p_push) else $error("push gate");
  property p_busy; status_byte[0] == (req_valid | array_busy); endproperty
  a_busy: assert property (p_busy) else $error("busy bit");
  // Output enable
  property p_off; s_idle |-> so_oe_n; endproperty
  a_off: assert property (p_off) else $error("output on idle");
  property p_in; s_on |-> !$past(cs_n, 4); endproperty
  a_in: assert property (p_in) else $error("output off frame");
  property p_byte; s_on |=> !so_oe_n [*8]; endproperty
  a_byte: assert property (p_byte) else $error("short byte");
endmodule : sfc_monitor
bind serial_flash_command_decoder sfc_monitor sfc_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .cs_n(cs_n), .so_oe_n(so_oe_n), .array_busy(array_busy), .req_valid(req_valid),
  .write_enable_latch(write_enable_latch), .status_byte(status_byte));
`default_nettype wire

// [test/spi_host.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Host side of the link, mode 0, 160 ns serial clock
module spi_host (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  // Idle pins
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end
  // One frame; a released output reads high
  task automatic run(input int nbits);
    rx_q.delete();
    #7 cs_n = 1'h0;
    for (int i = 0; i < nbits; i++) begin
      si = tx_q[i / 8][7 - i % 8];
      #80 sck = 1'h1;
      sh = {sh[6:0], so | so_oe_n};
      if (i % 8 == 7) rx_q.push_back(sh);
      #80 sck = 1'h0;
    end
    #80 cs_n = 1'h1;
    si = ~si;
    #100;
  endtask : run
endmodule : spi_host
`default_nettype wire

// [test/test_serial_flash_command_decoder.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Random and directed checks of the decoder
module test_serial_flash_command_decoder;
  import sfc_pkg::*;
  localparam logic [7:0] SIG = 8'h3e; // Arbitrary value
  localparam logic [7:0] MK = 8'hc5; // Arbitrary value
  logic ref_clk, rst_n, sck, cs_n, si, so, so_oe_n, req_valid, req_ready, write_enable_latch;
  logic [23:0] rd_addr, a;
  logic [7:0] status_byte;
  array_req_t req;
  int n_fail, compares, cyc, n;
  array_op_t ops[6] = '{OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_CHIP_ERASE,
    OP_BYTE_PROGRAM, OP_WORD_PROGRAM};
  logic [7:0] opc[6] = '{OPC_SECTOR_ERASE, OPC_BLOCK_ERASE, OPC_CHIP_ERASE_A,
    OPC_CHIP_ERASE_B, OPC_BYTE_PROGRAM, OPC_WORD_PROGRAM};
  int nb[6] = '{32, 32, 8, 8, 40, 48};
  // Array contents seen through the read port
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ 8'h5a;
  endfunction : mem
  serial_flash_command_decoder #(.SIGNATURE(SIG), .MAKER_CODE(MK)) serial_flash_command_decoder_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(1'h1), .so(so),
    .so_oe_n(so_oe_n), .rd_addr(rd_addr), .rd_data(mem(rd_addr)), .array_busy(1'h0),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .write_enable_latch(write_enable_latch), .status_byte(status_byte));
  spi_host spi_host_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
  // Compare and report
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // One frame, then let the command land
  task automatic send(input logic [7:0] op, input logic [23:0] ad, input int nbits);
    spi_host_i.tx_q = {op, ad[23:16], ad[15:8], ad[7:0], ad[15:8], ad[7:0]};
    spi_host_i.run(nbits);
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : send
  task automatic pop();
    req_ready = 1'h1;
    @(posedge ref_clk);
    #1 req_ready = 1'h0;
    @(posedge ref_clk);
    #1;
  endtask : pop
  // Clock and hang guard
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    rst_n = 1'h0;
    req_ready = 1'h0;
    void'($urandom(21247));
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'h1;
    @(posedge ref_clk);
    #1 check("status", status_byte, 8'h1c);
    repeat (3) @(posedge ref_clk);
    send(OPC_SECTOR_ERASE, 24'h0, 32);
    check("refuse", req_valid, 1'h0);
    foreach (ops[i]) begin
      a = 24'($urandom) & 24'hff_fffe;
      send(OPC_WRITE_ENABLE, a, 8);
      check("set", write_enable_latch, 1'h1);
      send(opc[i], a, nb[i]);
      check("op", req.op, ops[i]);
      if (nb[i] > 8) check("addr", req.addr, a);
      if (i == 4) check("data", req.data[7:0], a[15:8]);
      if (i == 5) check("word", req.data, a[15:0]);
      if (i < 5) check("clear", write_enable_latch, 1'h0);
      pop();
    end
    send(OPC_BUSY_OUT_EN, a, 8);
    check("busy on", {so_oe_n, so}, 2'h1);
    send(OPC_BUSY_OUT_DIS, a, 8);
    check("busy off", {so_oe_n, so}, 2'h3);
    send(OPC_WRITE_DISABLE, a, 8);
    check("disable", status_byte[6:1], 6'h0e);
    send(OPC_WRITE_ENABLE, a, 8);
    send(OPC_SECTOR_ERASE, a, 30);
    check("abort", {req_valid, write_enable_latch}, 2'h1);
    send(OPC_STATUS_READ, a, 24);
    check("rdsts", {spi_host_i.rx_q[1], spi_host_i.rx_q[2]}, 16'h1e1e);
    check("idle", so_oe_n, 1'h1);
    send(OPC_STATUS_UNLOCK, a, 8);
    send(OPC_STATUS_WRITE, 24'h0, 16);
    check("wrsts", status_byte, 8'h00);
    send(OPC_READ, a, 48);
    check("read", {spi_host_i.rx_q[4], spi_host_i.rx_q[5]}, {mem(a), mem(a + 24'h00_0001)});
    send(OPC_FAST_READ, a, 48);
    check("fast", spi_host_i.rx_q[5], mem(a));
    send(OPC_SIGNATURE, a, 16);
    check("sig", spi_host_i.rx_q[1], SIG);
    send(OPC_STD_ID, a, 16);
    check("id", spi_host_i.rx_q[1], MK);
    send(OPC_MAKER_DEV_ID, a, 40);
    check("maker", spi_host_i.rx_q[4], MK);
    send(OPC_BUSY_OUT_EN, a, 8);
    send(OPC_BUSY_OUT_DIS, a, 8);
    repeat (17) begin
      send(OPC_WRITE_ENABLE, a, 8);
      send(OPC_CHIP_ERASE_A, a, 8);
    end
    check("full", write_enable_latch, 1'h1);
    n = 0;
    while (req_valid === 1'h1 && n < 20) begin
      pop();
      n++;
    end
    check("depth", n, 16);
    print_verdict();
  end
endmodule : test_serial_flash_command_decoder
`default_nettype wire
